// ===== tlec_regs.vh
// Purpose: Register map, field positions, reset values and AXI response codes of the
//          two-level event controller.
// Assumes: AXI4-Lite slave with 32-bit data, one register per aligned word.
// Notes:   Definitions only.
`ifndef TLEC_REGS_VH
`define TLEC_REGS_VH

// ==========================================================================
// Register byte addresses
`define TLEC_ADDR_LATCHED     8'h00
`define TLEC_ADDR_EVMASK      8'h04
`define TLEC_ADDR_PENDING     8'h08
`define TLEC_ADDR_PMASK       8'h0C
`define TLEC_ADDR_PSTATUS     8'h10
`define TLEC_ADDR_WAKE        8'h14
`define TLEC_ADDR_CTRL        8'h18
`define TLEC_ADDR_INTSTAT     8'h1C
`define TLEC_ADDR_INTMASK     8'h20
`define TLEC_ADDR_ROUTE0      8'h24
`define TLEC_ADDR_ROUTE1      8'h28
`define TLEC_ADDR_ROUTE2      8'h2C
`define TLEC_ADDR_ROUTE3      8'h30

// ==========================================================================
// Reset values
`define TLEC_RST_EV16         16'h0000
`define TLEC_RST_P32          32'h00000000
`define TLEC_RST_ROUTE0       32'h00000000
`define TLEC_RST_ROUTE1       32'h00000000
`define TLEC_RST_ROUTE2       32'h66655400
`define TLEC_RST_ROUTE3       32'h00000000

// ==========================================================================
// Field positions and sizes
`define TLEC_NUM_EVENTS       16
`define TLEC_NUM_SRC          32
`define TLEC_GP_BASE          7
`define TLEC_NUM_GP           9
`define TLEC_ROUTE_W          4
`define TLEC_CTRL_GIE_BIT     0
`define TLEC_INT_ENTRY_BIT    0
`define TLEC_INT_WAKE_BIT     1
`define TLEC_INT_DENY_BIT     2
`define TLEC_INT_W            3

// ==========================================================================
// AXI responses
`define TLEC_RESP_OKAY        2'h0
`define TLEC_RESP_SLVERR      2'h2
`define TLEC_RESP_DECERR      2'h3

`endif

// ===== tlec_top.v
// Purpose: Two-level event controller: a system stage that masks and routes
//          32 peripheral requests onto general-purpose inputs, and a core stage
//          with 16-bit latched, mask and pending event registers.
// Assumes: Single 25 MHz clock aclk, synchronous active-low reset aresetn.
//          Peripheral requests are asynchronous pins; pipeline signals are on aclk.
// Notes:   Privilege comes from the AXI protection bit 0.
//
// Contract
// - Core stage has three 16-bit event registers.
// - Latch sets on event, clears on acceptance.
// - Software latch writes only where mask clear.
// - Mask bit set allows servicing; clear blocks.
// - Event mask accessible in supervisor mode only.
// - Global enable/disable instructions gate general-purpose events.
// - Pending keeps every active or nested event.
// - Pending updated by hardware; supervisor reads only.
// - System stage has 32-bit mask, status, wake.
// - Peripheral mask bit passes or blocks request.
// - Status shows which peripherals assert requests.
// - Wake-enabled peripheral event wakes idle core.
// - Pending bits serve as the acknowledgement.
// - Rising edge sets latch; detection takes two cycles.
// - Latch clears when matching pending bit sets.
// - Next edge queued once pending is set.
// - At least three cycles edge to pending.
// - Watchdog source 23 routes to event 13.
`include "tlec_regs.vh"
`timescale 1ns/1ps

module tlec_top
(
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [31:0] s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [31:0] periph_irq_req,
  input  wire [6:0]  core_sys_event,
  input  wire        global_irq_enable_instr,
  input  wire        global_irq_disable_instr,
  input  wire        event_return,
  input  wire [3:0]  event_return_index,
  input  wire        core_idle,
  output reg  [15:0] pending_events,
  output reg         event_entry,
  output reg  [3:0]  event_entry_index,
  output reg         wake_core,
  output reg         irq
);

  // ==========================================================================
  // State
  reg  [15:0]  latched_events;
  reg  [15:0]  event_mask;
  reg  [31:0]  periph_irq_mask;
  reg  [31:0]  periph_req_s1;
  reg  [31:0]  periph_irq_status;
  reg  [31:0]  periph_wake_enable;
  reg  [127:0] route;
  reg          global_enable;
  reg  [15:0]  raw_q;
  reg  [15:0]  raw_q2;
  reg  [2:0]   int_status;
  reg  [2:0]   int_mask;

  reg          aw_held;
  reg          w_held;
  reg          ar_held;
  reg  [7:0]   aw_addr;
  reg          aw_priv;
  reg  [31:0]  w_data;
  reg  [3:0]   w_strb;
  reg  [7:0]   ar_addr;
  reg          ar_priv;

  // ==========================================================================
  // Byte-lane merge for partial writes
  function [31:0] tlec_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  strb;
    integer      b;
    begin
      tlec_merge = old_val;
      for (b = 0; b < 4; b = b + 1)
      begin
        if (strb[b])
        begin
          tlec_merge[b*8 +: 8] = new_val[b*8 +: 8];
        end
      end
    end
  endfunction

  // ==========================================================================
  // AXI handshake bookkeeping
  wire aw_fire  = s_axi_awvalid & s_axi_awready;
  wire w_fire   = s_axi_wvalid & s_axi_wready;
  wire ar_fire  = s_axi_arvalid & s_axi_arready;
  wire do_write = aw_held & w_held & ~s_axi_bvalid;
  wire do_read  = ar_held & ~s_axi_rvalid;

  wire next_aw_held = (aw_held & ~do_write) | aw_fire;
  wire next_w_held  = (w_held & ~do_write) | w_fire;
  wire next_ar_held = (ar_held & ~do_read) | ar_fire;
  wire next_rvalid  = do_read | (s_axi_rvalid & ~s_axi_rready);

  // Register kinds that need supervisor privilege.
  wire w_priv_reg = (aw_addr == `TLEC_ADDR_EVMASK) || (aw_addr == `TLEC_ADDR_PENDING);
  wire r_priv_reg = (ar_addr == `TLEC_ADDR_EVMASK) || (ar_addr == `TLEC_ADDR_PENDING);
  wire w_denied   = do_write & w_priv_reg & ~aw_priv;
  wire r_denied   = do_read & r_priv_reg & ~ar_priv;
  wire w_ok       = do_write & ~w_denied;

  reg         w_mapped;
  reg         r_mapped;
  reg  [31:0] r_value;

  always @*
  begin
    case (aw_addr)
      `TLEC_ADDR_LATCHED, `TLEC_ADDR_EVMASK, `TLEC_ADDR_PENDING, `TLEC_ADDR_PMASK,
      `TLEC_ADDR_PSTATUS, `TLEC_ADDR_WAKE, `TLEC_ADDR_CTRL, `TLEC_ADDR_INTSTAT,
      `TLEC_ADDR_INTMASK, `TLEC_ADDR_ROUTE0, `TLEC_ADDR_ROUTE1, `TLEC_ADDR_ROUTE2,
      `TLEC_ADDR_ROUTE3: w_mapped = 1'b1;
      default:           w_mapped = 1'b0;
    endcase
  end

  always @*
  begin
    r_mapped = 1'b1;
    case (ar_addr)
      `TLEC_ADDR_LATCHED: r_value = {16'h0000, latched_events};
      `TLEC_ADDR_EVMASK:  r_value = {16'h0000, event_mask};
      `TLEC_ADDR_PENDING: r_value = {16'h0000, pending_events};
      `TLEC_ADDR_PMASK:   r_value = periph_irq_mask;
      `TLEC_ADDR_PSTATUS: r_value = periph_irq_status;
      `TLEC_ADDR_WAKE:    r_value = periph_wake_enable;
      `TLEC_ADDR_CTRL:    r_value = {31'h00000000, global_enable};
      `TLEC_ADDR_INTSTAT: r_value = {29'h00000000, int_status};
      `TLEC_ADDR_INTMASK: r_value = {29'h00000000, int_mask};
      `TLEC_ADDR_ROUTE0:  r_value = route[31:0];
      `TLEC_ADDR_ROUTE1:  r_value = route[63:32];
      `TLEC_ADDR_ROUTE2:  r_value = route[95:64];
      `TLEC_ADDR_ROUTE3:  r_value = route[127:96];
      default:
      begin
        r_value  = 32'h00000000;
        r_mapped = 1'b0;
      end
    endcase
  end

  wire wr_latched = w_ok & (aw_addr == `TLEC_ADDR_LATCHED);
  wire wr_intstat = w_ok & (aw_addr == `TLEC_ADDR_INTSTAT);
  wire [31:0] wr_bits = tlec_merge(32'h00000000, 32'hFFFFFFFF, w_strb);
  wire [31:0] evmask_merged  = tlec_merge({16'h0000, event_mask}, w_data, w_strb);
  wire [31:0] intmask_merged = tlec_merge({29'h00000000, int_mask}, w_data, w_strb);

  // ==========================================================================
  // System stage: request synchroniser, mask and routing
  reg [8:0] gp_in;
  integer   s;
  integer   g;

  always @*
  begin
    gp_in = 9'h000;
    for (s = 0; s < `TLEC_NUM_SRC; s = s + 1)
    begin
      for (g = 0; g < `TLEC_NUM_GP; g = g + 1)
      begin
        if (periph_irq_status[s] && periph_irq_mask[s] &&
            (route[s*`TLEC_ROUTE_W +: `TLEC_ROUTE_W] == g[3:0]))
        begin
          gp_in[g] = 1'b1;
        end
      end
    end
  end

  wire [15:0] raw_events = {gp_in, core_sys_event};
  // Edge detection spans two flops so the latch follows two cycles after the input.
  wire [15:0] edge_set   = raw_q & ~raw_q2;

  // ==========================================================================
  // Core stage: priority selection and nesting
  wire [15:0] gp_gate = {{`TLEC_NUM_GP{global_enable}}, 7'h7F};
  wire [15:0] cand    = latched_events & event_mask & gp_gate;

  reg  [3:0] sel_idx;
  reg        sel_any;
  reg  [4:0] low_pend;
  integer    k;

  always @*
  begin
    sel_idx  = 4'h0;
    sel_any  = 1'b0;
    low_pend = 5'h10;
    for (k = `TLEC_NUM_EVENTS - 1; k >= 0; k = k - 1)
    begin
      if (cand[k])
      begin
        sel_idx = k[3:0];
        sel_any = 1'b1;
      end
      if (pending_events[k])
      begin
        low_pend = {1'b0, k[3:0]};
      end
    end
  end

  // Only an event of higher priority than every active one may nest on top.
  wire        accept     = sel_any & ({1'b0, sel_idx} < low_pend);
  wire [15:0] entry_mask = accept ? (16'h0001 << sel_idx) : 16'h0000;
  wire [15:0] ret_mask   = event_return ? (16'h0001 << event_return_index) : 16'h0000;
  wire [15:0] sw_lat_en  = wr_latched ? (~event_mask & wr_bits[15:0]) : 16'h0000;

  wire [15:0] next_latched = (((latched_events & ~sw_lat_en) | (w_data[15:0] & sw_lat_en))
                             & ~entry_mask)
                             | edge_set;
  wire [15:0] next_pending = (pending_events & ~ret_mask) | entry_mask;

  wire        wake_hit = |(periph_irq_status & periph_wake_enable);
  wire [2:0]  int_set  = {w_denied | r_denied, core_idle & wake_hit, accept};

  // ==========================================================================
  // Sequential logic
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready      <= 1'b0;
      s_axi_wready       <= 1'b0;
      s_axi_arready      <= 1'b0;
      s_axi_bvalid       <= 1'b0;
      s_axi_bresp        <= `TLEC_RESP_OKAY;
      s_axi_rvalid       <= 1'b0;
      s_axi_rresp        <= `TLEC_RESP_OKAY;
      s_axi_rdata        <= 32'h00000000;
      aw_held            <= 1'b0;
      w_held             <= 1'b0;
      ar_held            <= 1'b0;
      aw_addr            <= 8'h00;
      aw_priv            <= 1'b0;
      ar_addr            <= 8'h00;
      ar_priv            <= 1'b0;
      w_data             <= 32'h00000000;
      w_strb             <= 4'h0;
      latched_events     <= `TLEC_RST_EV16;
      event_mask         <= `TLEC_RST_EV16;
      pending_events     <= `TLEC_RST_EV16;
      periph_irq_mask    <= `TLEC_RST_P32;
      periph_req_s1      <= `TLEC_RST_P32;
      periph_irq_status  <= `TLEC_RST_P32;
      periph_wake_enable <= `TLEC_RST_P32;
      route              <= {`TLEC_RST_ROUTE3, `TLEC_RST_ROUTE2,
                             `TLEC_RST_ROUTE1, `TLEC_RST_ROUTE0};
      global_enable      <= 1'b0;
      raw_q              <= 16'h0000;
      raw_q2             <= 16'h0000;
      int_status         <= 3'h0;
      int_mask           <= 3'h0;
      event_entry        <= 1'b0;
      event_entry_index  <= 4'h0;
      wake_core          <= 1'b0;
      irq                <= 1'b0;
    end
    else
    begin
      // Bus channels.
      aw_held       <= next_aw_held;
      w_held        <= next_w_held;
      ar_held       <= next_ar_held;
      s_axi_awready <= ~next_aw_held;
      s_axi_wready  <= ~next_w_held;
      s_axi_arready <= ~next_ar_held & ~next_rvalid;
      if (aw_fire)
      begin
        aw_addr <= s_axi_awaddr[7:0] & 8'hFC;
        aw_priv <= s_axi_awprot[0];
      end
      if (w_fire)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (ar_fire)
      begin
        ar_addr <= s_axi_araddr[7:0] & 8'hFC;
        ar_priv <= s_axi_arprot[0];
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= !w_mapped ? `TLEC_RESP_DECERR :
                        w_denied  ? `TLEC_RESP_SLVERR : `TLEC_RESP_OKAY;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_rvalid <= next_rvalid;
      if (do_read)
      begin
        s_axi_rdata <= r_denied ? 32'h00000000 : r_value;
        s_axi_rresp <= !r_mapped ? `TLEC_RESP_DECERR :
                       r_denied  ? `TLEC_RESP_SLVERR : `TLEC_RESP_OKAY;
      end

      // Software-written registers.
      if (w_ok)
      begin
        case (aw_addr)
          `TLEC_ADDR_EVMASK:  event_mask <= evmask_merged[15:0];
          `TLEC_ADDR_PMASK:   periph_irq_mask    <= tlec_merge(periph_irq_mask, w_data, w_strb);
          `TLEC_ADDR_WAKE:    periph_wake_enable <= tlec_merge(periph_wake_enable, w_data,
                                                               w_strb);
          `TLEC_ADDR_INTMASK: int_mask <= intmask_merged[2:0];
          `TLEC_ADDR_ROUTE0:  route[31:0]   <= tlec_merge(route[31:0], w_data, w_strb);
          `TLEC_ADDR_ROUTE1:  route[63:32]  <= tlec_merge(route[63:32], w_data, w_strb);
          `TLEC_ADDR_ROUTE2:  route[95:64]  <= tlec_merge(route[95:64], w_data, w_strb);
          `TLEC_ADDR_ROUTE3:  route[127:96] <= tlec_merge(route[127:96], w_data, w_strb);
          default:
          begin
            periph_irq_mask <= periph_irq_mask;
          end
        endcase
      end

      // Global enable; a disable in the same cycle as an enable wins for safety.
      if (global_irq_disable_instr)
      begin
        global_enable <= 1'b0;
      end
      else if (global_irq_enable_instr)
      begin
        global_enable <= 1'b1;
      end

      // Event path.
      periph_req_s1     <= periph_irq_req;
      periph_irq_status <= periph_req_s1;
      raw_q             <= raw_events;
      raw_q2            <= raw_q;
      latched_events    <= next_latched;
      pending_events    <= next_pending;
      event_entry       <= accept;
      event_entry_index <= sel_idx;
      wake_core         <= core_idle & wake_hit;

      // Sticky interrupt status: a new event wins over a write-one clear.
      int_status <= (int_status & ~(wr_intstat ? w_data[2:0] & {3{w_strb[0]}} : 3'h0))
                    | int_set;
      irq        <= |(((int_status & ~(wr_intstat ? w_data[2:0] & {3{w_strb[0]}} : 3'h0))
                      | int_set) & int_mask);
    end
  end

endmodule // tlec_top

// ===== tlec_pipe_model.sv
// Purpose: Pipeline model that retires each entered event after a delay.
// Assumes: Entries nest; the newest one is retired first.
// Notes:   A hold of zero parks every entered event until hold changes.
`timescale 1ns/1ps
module tlec_pipe_model
(
  input  wire       aclk,
  input  wire       aresetn,
  input  wire [7:0] hold,
  input  wire       event_entry,
  input  wire [3:0] event_entry_index,
  output reg        event_return,
  output reg  [3:0] event_return_index
);
  // ==========================================================================
  // Nesting stack
  reg [3:0] stk [0:15];
  reg [4:0] sp;
  reg [7:0] cnt;

  // The index toggles when idle so that a stale value is never mistaken for a return.
  always @(posedge aclk)
  begin
    event_return <= 1'h0;
    event_return_index <= ~event_return_index;
    if (!aresetn)
    begin
      sp <= 5'h00;
      event_return_index <= 4'h0;
    end
    else if (event_entry)
    begin
      stk[sp[3:0]] <= event_entry_index;
      sp <= sp + 5'h01;
      cnt <= hold;
    end
    else if (sp != 5'h00 && hold != 8'h00)
    begin
      cnt <= cnt - 8'h01;
      if (cnt <= 8'h01)
      begin
        event_return <= 1'h1;
        event_return_index <= stk[sp[3:0] - 4'h1];
        sp <= sp - 5'h01;
        cnt <= hold;
      end
    end
  end
endmodule // tlec_pipe_model

// ===== tlec_props.sv
// Purpose: Concurrent checks on the event controller ports.
// Assumes: One clock, synchronous active-low reset.
// Notes:   The global enable is mirrored from the instruction pulses.
`timescale 1ns/1ps
module tlec_props
(
  input wire        aclk,
  input wire        aresetn,
  input wire [31:0] s_axi_araddr,
  input wire [2:0]  s_axi_arprot,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire [6:0]  core_sys_event,
  input wire        global_irq_enable_instr,
  input wire        global_irq_disable_instr,
  input wire        event_return,
  input wire [3:0]  event_return_index,
  input wire        core_idle,
  input wire [15:0] pending_events,
  input wire        event_entry,
  input wire [3:0]  event_entry_index,
  input wire        wake_core
);
  // ==========================================================================
  // Helpers
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  reg gie_m;
  always @(posedge aclk)
    if (!aresetn)
      gie_m <= 1'h0;
    else if (global_irq_disable_instr)
      gie_m <= 1'h0;
    else if (global_irq_enable_instr)
      gie_m <= 1'h1;
  sequence user_evmask_read;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:0] == 8'h04 && !s_axi_arprot[0];
  endsequence
  sequence no_entry0;
    !(event_entry && event_entry_index == 4'h0);
  endsequence

  // ==========================================================================
  // Assertions
  entry_sets_pend_a: assert property (event_entry |-> pending_events[event_entry_index])
    else $error("entered event not pending");
  entry_lowest_a: assert property (event_entry |->
    (pending_events & ((16'h0001 << event_entry_index) - 16'h0001)) == 16'h0000)
    else $error("entry below a pending event");
  pend_rise_a: assert property ($past(aresetn) |-> (pending_events & ~$past(pending_events))
    == (event_entry ? (16'h0001 << event_entry_index) : 16'h0000))
    else $error("pending bit set without entry");
  pend_fall_a: assert property ($past(aresetn) |-> ($past(pending_events) & ~pending_events
    & ~($past(event_return) ? (16'h0001 << $past(event_return_index)) : 16'h0000)) == 16'h0000)
    else $error("pending bit dropped without return");
  gie_gate_a: assert property (event_entry && event_entry_index >= 4'h7 |-> gie_m || $past(gie_m))
    else $error("general event entered while disabled");
  wake_idle_a: assert property (wake_core && $past(aresetn) |-> $past(core_idle))
    else $error("wake while core busy");
  priv_deny_a: assert property (user_evmask_read |-> ##2
    s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h00000000)
    else $error("user mask read not refused");
  min_latency_a: assert property ($rose(core_sys_event[0]) |-> no_entry0 ##1 no_entry0 ##1 no_entry0)
    else $error("entry sooner than three cycles");
endmodule // tlec_props

// ===== tlec_top_tb.sv
// Purpose: Self-checking bench for the two-level event controller.
// Assumes: Register map at byte offsets 0x00 to 0x30, supervisor on prot bit 0.
// Notes:   Latency counts include one edge to observe the registered output.
`timescale 1ns/1ps
module tlec_top_tb;
  // ==========================================================================
  // Signals
  reg         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  reg         s_axi_rready, global_irq_enable_instr, global_irq_disable_instr, core_idle;
  reg  [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, periph_irq_req;
  reg  [2:0]  s_axi_awprot, s_axi_arprot;
  reg  [3:0]  s_axi_wstrb;
  reg  [6:0]  core_sys_event;
  reg  [7:0]  hold;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire        event_return, event_entry, wake_core, irq;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [3:0]  event_return_index, event_entry_index;
  wire [15:0] pending_events;
  integer     failures, total_checks, cyc;

  tlec_top tlec_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .periph_irq_req, .core_sys_event,
    .global_irq_enable_instr, .global_irq_disable_instr, .event_return, .event_return_index,
    .core_idle, .pending_events, .event_entry, .event_entry_index, .wake_core, .irq);
  tlec_pipe_model tlec_pipe_model_inst (.aclk, .aresetn, .hold, .event_entry,
    .event_entry_index, .event_return, .event_return_index);

  // ==========================================================================
  // Tasks
  task chk(input [31:0] g, input [31:0] e);
    begin
      total_checks = total_checks + 1;
      if (g !== e)
      begin
        failures = failures + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task bus(input w, input [7:0] a, input [31:0] d, input p, input [1:0] er, input [31:0] ed);
    begin
      s_axi_awaddr <= {24'h000000, a};
      s_axi_araddr <= {24'h000000, a};
      s_axi_awprot <= {2'h0, p};
      s_axi_arprot <= {2'h0, p};
      s_axi_wdata <= d;
      s_axi_awvalid <= w;
      s_axi_wvalid <= w;
      s_axi_bready <= w;
      s_axi_arvalid <= !w;
      s_axi_rready <= !w;
      do
      begin
        @(posedge aclk);
        if (s_axi_awready)
          s_axi_awvalid <= 1'h0;
        if (s_axi_wready)
          s_axi_wvalid <= 1'h0;
        if (s_axi_arready)
          s_axi_arvalid <= 1'h0;
      end while (!(w ? s_axi_bvalid : s_axi_rvalid));
      s_axi_bready <= 1'h0;
      s_axi_rready <= 1'h0;
      chk(w ? s_axi_bresp : s_axi_rresp, er);
      if (!w)
        chk(s_axi_rdata, ed);
      @(posedge aclk);
    end
  endtask
  task wait_entry(input [3:0] ix, input integer lat);
    integer n;
    begin
      n = 0;
      do
      begin
        @(posedge aclk);
        n = n + 1;
      end while (!event_entry && n < 60);
      chk(event_entry, 1'h1);
      chk(event_entry_index, ix);
      if (lat > 0)
        chk(n, lat);
    end
  endtask
  task pulse(input en);
    begin
      global_irq_enable_instr <= en;
      global_irq_disable_instr <= !en;
      @(posedge aclk);
      global_irq_enable_instr <= 1'h0;
      global_irq_disable_instr <= 1'h0;
      @(posedge aclk);
    end
  endtask
  task end_of_test;
    begin
      $display("checks=%0d failures=%0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask

  // ==========================================================================
  // Scenarios
  task t_regs;
    begin
      bus(1'h0, 8'h08, 32'h0, 1'h1, 2'h0, 32'h0);
      bus(1'h0, 8'h2C, 32'h0, 1'h1, 2'h0, 32'h66655400);
      bus(1'h1, 8'h0C, 32'hA5A5F00F, 1'h1, 2'h0, 32'h0);
      bus(1'h0, 8'h0C, 32'h0, 1'h1, 2'h0, 32'hA5A5F00F);
      bus(1'h1, 8'h10, 32'hFFFFFFFF, 1'h1, 2'h0, 32'h0);
      bus(1'h0, 8'h10, 32'h0, 1'h1, 2'h0, 32'h0);
      bus(1'h0, 8'h40, 32'h0, 1'h1, 2'h3, 32'h0);
      bus(1'h1, 8'h04, 32'hFFFF, 1'h0, 2'h2, 32'h0);
      bus(1'h0, 8'h04, 32'h0, 1'h0, 2'h2, 32'h0);
      bus(1'h0, 8'h04, 32'h0, 1'h1, 2'h0, 32'h0);
      bus(1'h0, 8'h08, 32'h0, 1'h0, 2'h2, 32'h0);
      bus(1'h1, 8'h08, 32'hFFFF, 1'h1, 2'h0, 32'h0);
      bus(1'h0, 8'h08, 32'h0, 1'h1, 2'h0, 32'h0);
      $display("test regs done");
    end
  endtask
  task t_core;
    begin
      hold <= 8'h00;
      bus(1'h1, 8'h04, 32'h4, 1'h1, 2'h0, 32'h0);
      core_sys_event <= 7'h0C;
      wait_entry(4'h2, 4);
      bus(1'h0, 8'h08, 32'h0, 1'h1, 2'h0, 32'h4);
      bus(1'h0, 8'h00, 32'h0, 1'h1, 2'h0, 32'h8);
      core_sys_event <= 7'h00;
      @(posedge aclk);
      core_sys_event <= 7'h04;
      repeat (4) @(posedge aclk);
      bus(1'h0, 8'h00, 32'h0, 1'h1, 2'h0, 32'hC);
      bus(1'h1, 8'h00, 32'h0, 1'h1, 2'h0, 32'h0);
      bus(1'h0, 8'h00, 32'h0, 1'h1, 2'h0, 32'h4);
      hold <= 8'h04;
      wait_entry(4'h2, 0);
      core_sys_event <= 7'h00;
      repeat (10) @(posedge aclk);
      chk(pending_events, 16'h0000);
      $display("test core done");
    end
  endtask
  task t_nest;
    begin
      hold <= 8'h00;
      bus(1'h1, 8'h04, 32'h3, 1'h1, 2'h0, 32'h0);
      core_sys_event <= 7'h02;
      wait_entry(4'h1, 4);
      core_sys_event <= 7'h03;
      wait_entry(4'h0, 4);
      bus(1'h0, 8'h08, 32'h0, 1'h1, 2'h0, 32'h3);
      core_sys_event <= 7'h00;
      @(posedge aclk);
      core_sys_event <= 7'h03;
      repeat (4) @(posedge aclk);
      hold <= 8'h02;
      wait_entry(4'h0, 0);
      wait_entry(4'h1, 0);
      core_sys_event <= 7'h00;
      $display("test nest done");
    end
  endtask
  task t_periph;
    begin
      hold <= 8'h04;
      bus(1'h1, 8'h0C, 32'h00800000, 1'h1, 2'h0, 32'h0);
      bus(1'h1, 8'h04, 32'h2000, 1'h1, 2'h0, 32'h0);
      bus(1'h1, 8'h1C, 32'h7, 1'h1, 2'h0, 32'h0);
      bus(1'h1, 8'h20, 32'h1, 1'h1, 2'h0, 32'h0);
      pulse(1'h1);
      chk(irq, 1'h0);
      periph_irq_req <= 32'h00800000;
      wait_entry(4'hD, 6);
      chk(irq, 1'h1);
      bus(1'h0, 8'h10, 32'h0, 1'h1, 2'h0, 32'h00800000);
      periph_irq_req <= 32'h0;
      bus(1'h1, 8'h1C, 32'h7, 1'h1, 2'h0, 32'h0);
      chk(irq, 1'h0);
      bus(1'h1, 8'h0C, 32'h0, 1'h1, 2'h0, 32'h0);
      hold <= 8'h00;
      periph_irq_req <= 32'h00800000;
      repeat (12) @(posedge aclk);
      chk(pending_events, 16'h0000);
      bus(1'h0, 8'h10, 32'h0, 1'h1, 2'h0, 32'h00800000);
      periph_irq_req <= 32'h0;
      bus(1'h1, 8'h0C, 32'h00800000, 1'h1, 2'h0, 32'h0);
      pulse(1'h0);
      periph_irq_req <= 32'h00800000;
      repeat (12) @(posedge aclk);
      chk(pending_events, 16'h0000);
      $display("test periph done");
    end
  endtask
  task t_wake;
    begin
      periph_irq_req <= 32'h0;
      bus(1'h1, 8'h14, 32'h00080000, 1'h1, 2'h0, 32'h0);
      core_idle <= 1'h1;
      periph_irq_req <= 32'h00080000;
      repeat (5) @(posedge aclk);
      chk(wake_core, 1'h1);
      chk(irq, 1'h0);
      bus(1'h1, 8'h20, 32'h2, 1'h1, 2'h0, 32'h0);
      chk(irq, 1'h1);
      core_idle <= 1'h0;
      bus(1'h1, 8'h1C, 32'h2, 1'h1, 2'h0, 32'h0);
      chk(wake_core, 1'h0);
      chk(irq, 1'h0);
      $display("test wake done");
    end
  endtask

  // ==========================================================================
  // Clock, watchdog and main sequence
  initial
  begin
    aclk = 1'h0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      failures = failures + 1;
      end_of_test;
    end
  end
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {global_irq_enable_instr, global_irq_disable_instr, core_idle} = 3'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, periph_irq_req} = 128'h0;
    {s_axi_awprot, s_axi_arprot} = 6'h00;
    s_axi_wstrb = 4'hF;
    core_sys_event = 7'h00;
    hold = 8'h04;
    failures = 0;
    total_checks = 0;
    cyc = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_regs;
    t_core;
    t_nest;
    t_periph;
    t_wake;
    end_of_test;
  end
endmodule // tlec_top_tb

bind tlec_top tlec_props tlec_props_inst (.aclk, .aresetn, .s_axi_araddr, .s_axi_arprot,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .core_sys_event,
  .global_irq_enable_instr, .global_irq_disable_instr, .event_return, .event_return_index,
  .core_idle, .pending_events, .event_entry, .event_entry_index, .wake_core);
